// [verilog/wpi_injector.sv]
/*
 watermark pn injector: parses control packets, frames a three-tier
 sequence generator to the data field and adds a signed watermark level
 to each active-segment host symbol. assumes all inputs come from logic on sys_clk and
 that sym_valid is a one-cycle strobe per host symbol.
*/
// Operation
// - three maximal-length shift register tiers combine by xor into one bit; here each tier feeds back five taps, so none is maximal-length
// - every preload sets tier one to a single one in its fixed stage
// - tier two seeds from the network id, tier three from the transmitter id
// - generator steps exactly once per active-segment symbol, on the symbol strobe
// - code one adds plus amplitude, code zero adds minus amplitude
// - amplitude comes from bury-ratio table, -21 to -39 db, plus off
// - watermark level is summed with the host symbol before the converter
// - bury ratio comes from the addressed control packet, nominal -30 db
// - field sync symbols pass unchanged and the generator is preloaded then
// - sequence starts with the first active segment, runs 312 segments
// - a field holds three full periods then a period cut at 62979
// - one code bit per host symbol in active segments, two-level
// - control packets carry identifier 0x1ffa, purpose code, 183-byte payload
// - purpose codes 0x00 to 0x31 select transmitters or translator tiers
// - return channel may invert every watermark bit for one whole field
// - tiers use xor feedback only and take a parallel preload
`timescale 1ns/100ps
module wpi_injector #(
    parameter int                   SYM_W = wpi_pkg::SYM_W,
    parameter int                   FCNT_W_P = wpi_pkg::FCNT_W,
    parameter logic [FCNT_W_P-1:0]  FIELD_SYMS = wpi_pkg::FIELD_SYMS
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       sym_valid,
    input  wire logic                       field_sync,
    input  wire logic signed [SYM_W-1:0]    host_sym,
    input  wire logic                       ret_invert,
    input  wire logic [7:0]                 own_purpose,
    input  wire logic                       pkt_valid,
    input  wire logic                       pkt_start,
    input  wire logic [7:0]                 pkt_byte,
    output logic signed [SYM_W:0]           out_sym,
    output logic                            out_valid,
    output logic                            wm_active,
    output logic                            inverting,
    output logic [wpi_pkg::BURY_W-1:0]      bury_now,
    output logic                            cfg_taken
);
    localparam int AW = wpi_pkg::AMP_W;
    localparam int IW = wpi_pkg::ID_W;
    localparam int BW = wpi_pkg::BURY_W;
    localparam int PW = wpi_pkg::PCNT_W;

    // ------------------------------------------------------------
    // control packet parser
    // ------------------------------------------------------------
    wpi_pkg::wpi_pstate_t              pstate_r;
    logic [wpi_pkg::IDX_W-1:0]         idx_r;
    logic [12:0]                       pid_r;
    logic [7:0]                        purp_r;
    logic [IW-1:0]                     p_net_r;
    logic [IW-1:0]                     p_tx_r;
    logic [BW-1:0]                     p_bury_r;
    logic [IW-1:0]                     pend_net_r;
    logic [IW-1:0]                     pend_tx_r;
    logic [BW-1:0]                     pend_bury_r;
    logic                              hunt_hit;
    logic                              body_byte;
    logic                              pkt_end;
    logic                              pkt_ours;

    assign hunt_hit  = pkt_valid && pkt_start && (pkt_byte == wpi_pkg::TS_SYNC);
    assign body_byte = pkt_valid && (pstate_r == wpi_pkg::PS_BODY);
    assign pkt_end   = body_byte && (idx_r == wpi_pkg::IDX_LAST);
    assign pkt_ours  = (pid_r == wpi_pkg::DCP_PID)
                    && (purp_r <= wpi_pkg::PURPOSE_MAX)
                    && (purp_r == own_purpose);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pstate_r <= wpi_pkg::PS_HUNT;
            idx_r    <= '0;
        end
        else if (hunt_hit)
        begin
            pstate_r <= wpi_pkg::PS_BODY;
            idx_r    <= wpi_pkg::IDX_PID_HI;
        end
        else if (pkt_end)
            pstate_r <= wpi_pkg::PS_HUNT;
        else if (body_byte)
            idx_r <= idx_r + 8'h01;
    end

    // field capture; a restart mid-packet simply drops the old packet
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pid_r    <= '0;
            purp_r   <= '0;
            p_net_r  <= '0;
            p_tx_r   <= '0;
            p_bury_r <= '0;
        end
        else if (body_byte)
        begin
            unique case (idx_r)
                wpi_pkg::IDX_PID_HI:  pid_r[12:8]     <= pkt_byte[4:0];
                wpi_pkg::IDX_PID_LO:  pid_r[7:0]      <= pkt_byte;
                wpi_pkg::IDX_PURPOSE: purp_r          <= pkt_byte;
                wpi_pkg::IDX_NET_HI:  p_net_r[IW-1:8] <= pkt_byte[IW-9:0];
                wpi_pkg::IDX_NET_LO:  p_net_r[7:0]    <= pkt_byte;
                wpi_pkg::IDX_TX_HI:   p_tx_r[IW-1:8]  <= pkt_byte[IW-9:0];
                wpi_pkg::IDX_TX_LO:   p_tx_r[7:0]     <= pkt_byte;
                wpi_pkg::IDX_BURY:    p_bury_r        <= pkt_byte[BW-1:0];
                default:              pid_r           <= pid_r;
            endcase
        end
    end

    // accepted settings wait here until the next field sync
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_net_r  <= '0;
            pend_tx_r   <= '0;
            pend_bury_r <= wpi_pkg::BURY_NOMINAL;
            cfg_taken   <= 1'b0;
        end
        else
        begin
            cfg_taken <= pkt_end && pkt_ours;
            if (pkt_end && pkt_ours)
            begin
                pend_net_r  <= p_net_r;
                pend_tx_r   <= p_tx_r;
                pend_bury_r <= p_bury_r;
            end
        end
    end

    // ------------------------------------------------------------
    // field framing
    // ------------------------------------------------------------
    logic [FCNT_W_P-1:0] fcnt_r;
    logic [PW-1:0]       pcnt_r;
    logic [1:0]          period_r;
    logic                inv_r;
    logic                sync_sym;
    logic                act_sym;
    logic                period_end;

    // active only up to the field length; stray extra symbols pass clean
    assign sync_sym   = sym_valid && field_sync;
    assign act_sym    = sym_valid && !field_sync && (fcnt_r < FIELD_SYMS);
    assign period_end = act_sym && (pcnt_r == wpi_pkg::KASAMI_LEN - 16'h0001);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fcnt_r   <= FIELD_SYMS;
            pcnt_r   <= '0;
            period_r <= '0;
            inv_r    <= 1'b0;
            bury_now <= wpi_pkg::BURY_NOMINAL;
        end
        else if (sync_sym)
        begin
            fcnt_r   <= '0;
            pcnt_r   <= '0;
            period_r <= '0;
            inv_r    <= ret_invert;
            bury_now <= pend_bury_r;
        end
        else if (act_sym)
        begin
            fcnt_r <= fcnt_r + FCNT_W_P'(1);
            if (period_end)
            begin
                pcnt_r   <= '0;
                period_r <= period_r + 2'h1;
            end
            else
                pcnt_r <= pcnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // generator and amplitude
    // ------------------------------------------------------------
    wpi_gen_if gi ();
    logic [AW-1:0] amp;

    assign gi.preload = sync_sym;
    assign gi.advance = act_sym;
    assign gi.net_id  = pend_net_r;
    assign gi.tx_id   = pend_tx_r;

    wpi_kasami_gen u_gen (
        .sys_clk (sys_clk),
        .rst     (rst),
        .g       (gi.gen)
    );

    wpi_amp_sel u_amp (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .bury_code (bury_now),
        .amp       (amp)
    );

    // ------------------------------------------------------------
    // summing
    // ------------------------------------------------------------
    logic                 wm_bit;
    logic signed [SYM_W:0] amp_ext;
    logic signed [SYM_W:0] host_ext;
    logic signed [SYM_W:0] wm_val;
    logic signed [SYM_W:0] sum_nxt;

    // the sum is one bit wider so a full-scale host symbol cannot wrap
    assign wm_bit   = gi.code_bit ^ inv_r;
    assign amp_ext  = {{(SYM_W + 1 - AW){1'b0}}, amp};
    assign host_ext = {host_sym[SYM_W-1], host_sym};
    assign wm_val   = !act_sym ? '0 : (wm_bit ? amp_ext : -amp_ext);
    assign sum_nxt  = host_ext + wm_val;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_sym   <= '0;
            out_valid <= 1'b0;
            wm_active <= 1'b0;
            inverting <= 1'b0;
        end
        else
        begin
            out_valid <= sym_valid;
            wm_active <= act_sym;
            inverting <= inv_r;
            if (sym_valid)
                out_sym <= sum_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [FCNT_W_P-1:0] act_seen_r;

    // last symbol of a field; the default length gives LAST_PERIOD and one less than LAST_RUN
    localparam int            FLD_LAST   = int'(FIELD_SYMS) - 1;
    localparam int            PER_LEN    = int'(wpi_pkg::KASAMI_LEN);
    localparam logic [1:0]    END_PERIOD = 2'(FLD_LAST / PER_LEN);
    localparam logic [PW-1:0] END_RUN    = PW'(FLD_LAST % PER_LEN);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            act_seen_r <= '0;
        else if (sync_sym)
            act_seen_r <= '0;
        else if (act_sym)
            act_seen_r <= act_seen_r + FCNT_W_P'(1);
    end

    chk_sync_no_wm: assert property (@(posedge sys_clk) disable iff (rst)
        sync_sym |=> (out_sym == $past(host_ext)) && !wm_active)
        else $error("watermark added during field sync");

    chk_plus_level: assert property (@(posedge sys_clk) disable iff (rst)
        (act_sym && wm_bit) |=> (out_sym == $past(host_ext) + $past(amp_ext)))
        else $error("code one did not add plus amplitude");

    chk_minus_level: assert property (@(posedge sys_clk) disable iff (rst)
        (act_sym && !wm_bit) |=> (out_sym == $past(host_ext) - $past(amp_ext)))
        else $error("code zero did not add minus amplitude");

    chk_field_len: assert property (@(posedge sys_clk) disable iff (rst)
        act_seen_r <= FIELD_SYMS)
        else $error("more active symbols than one field");

    chk_trunc_period: assert property (@(posedge sys_clk) disable iff (rst)
        (act_sym && fcnt_r == FIELD_SYMS - FCNT_W_P'(1)) |->
            (period_r == END_PERIOD) && (pcnt_r == END_RUN))
        else $error("field end not at truncated fourth period");

    chk_invert_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !sync_sym |=> $stable(inv_r))
        else $error("inversion changed inside a field");

    chk_bury_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (pkt_end && pkt_ours) ##1 !sync_sym |-> (pend_bury_r == $past(p_bury_r)))
        else $error("accepted bury setting not held");

    chk_foreign_pkt: assert property (@(posedge sys_clk) disable iff (rst)
        (pkt_end && (pid_r != wpi_pkg::DCP_PID || purp_r > wpi_pkg::PURPOSE_MAX))
            |=> !cfg_taken && $stable(pend_bury_r))
        else $error("foreign packet changed settings");

    chk_one_step: assert property (@(posedge sys_clk) disable iff (rst)
        (gi.advance |-> sym_valid) and !(gi.advance && gi.preload))
        else $error("generator stepped without a symbol");
endmodule : wpi_injector

// [pkg/wpi_pkg.sv]
/*
 holds the shared constants of the watermark pn injector: field framing,
 generator seeds and taps, packet layout, bury-ratio amplitudes.
 assumes a symbol strobe on sys_clk and host symbols in signed fixed point.
*/
package wpi_pkg;
    // ------------------------------------------------------------
    // widths and framing
    // ------------------------------------------------------------
    localparam int SYM_W       = 12;
    localparam int FRAC_W      = 10;
    localparam int AMP_W       = 10;
    localparam int ID_W        = 12;
    localparam int TIER_W      = 16;
    localparam int BURY_W      = 3;
    localparam int FCNT_W      = 18;
    localparam int PCNT_W      = 16;
    localparam int IDX_W       = 8;
    localparam logic [FCNT_W-1:0] FIELD_SYMS  = 18'd259584;
    localparam logic [PCNT_W-1:0] KASAMI_LEN  = 16'hffff;
    localparam logic [PCNT_W-1:0] LAST_RUN    = 16'd62979;
    localparam logic [1:0]        LAST_PERIOD = 2'h3;
    // ------------------------------------------------------------
    // generator seeds and feedback taps
    // ------------------------------------------------------------
    localparam int                TIER1_X    = 15;
    localparam logic [TIER_W-1:0] TAPS_TIER1 = 16'hb401;
    localparam logic [TIER_W-1:0] TAPS_TIER2 = 16'hd009;
    localparam logic [TIER_W-1:0] TAPS_TIER3 = 16'h8017;
    // ------------------------------------------------------------
    // control packet layout (byte index within the 188-byte packet)
    // ------------------------------------------------------------
    localparam logic [7:0]       TS_SYNC       = 8'h47;
    localparam logic [12:0]      DCP_PID       = 13'h1ffa;
    localparam logic [7:0]       PURPOSE_MAX   = 8'h31;
    localparam logic [IDX_W-1:0] IDX_PID_HI    = 8'h01;
    localparam logic [IDX_W-1:0] IDX_PID_LO    = 8'h02;
    localparam logic [IDX_W-1:0] IDX_PURPOSE   = 8'h04;
    localparam logic [IDX_W-1:0] IDX_NET_HI    = 8'h05;
    localparam logic [IDX_W-1:0] IDX_NET_LO    = 8'h06;
    localparam logic [IDX_W-1:0] IDX_TX_HI     = 8'h07;
    localparam logic [IDX_W-1:0] IDX_TX_LO     = 8'h08;
    localparam logic [IDX_W-1:0] IDX_BURY      = 8'h09;
    localparam logic [IDX_W-1:0] IDX_LAST      = 8'hbb;
    // ------------------------------------------------------------
    // bury ratio codes and amplitudes, scaled by 2**FRAC_W
    // ------------------------------------------------------------
    localparam logic [BURY_W-1:0] BURY_NOMINAL = 3'h3;
    localparam logic [BURY_W-1:0] BURY_OFF     = 3'h7;
    localparam logic [AMP_W-1:0] AMP_M21 = 10'h1b2; // 0.4233442
    localparam logic [AMP_W-1:0] AMP_M24 = 10'h133; // 0.2997047
    localparam logic [AMP_W-1:0] AMP_M27 = 10'h0d9; // 0.2121747
    localparam logic [AMP_W-1:0] AMP_M30 = 10'h09a; // ~0.1502, geometric mean
    localparam logic [AMP_W-1:0] AMP_M33 = 10'h06d; // 0.1063393
    localparam logic [AMP_W-1:0] AMP_M36 = 10'h04d; // 7.528242E-02
    localparam logic [AMP_W-1:0] AMP_M39 = 10'h037; // 5.329588E-02
    localparam logic [AMP_W-1:0] AMP_ZERO = 10'h000;

    typedef enum logic [0:0] {PS_HUNT, PS_BODY} wpi_pstate_t;
endpackage : wpi_pkg

// [pkg/wpi_gen_if.sv]
/*
 carries the control of the sequence generator between the injector and
 the generator. assumes both sides run on sys_clk.
*/
`timescale 1ns/100ps
interface wpi_gen_if;
    logic                        preload;
    logic                        advance;
    logic [wpi_pkg::ID_W-1:0]    net_id;
    logic [wpi_pkg::ID_W-1:0]    tx_id;
    logic                        code_bit;
    modport gen (input preload, input advance, input net_id, input tx_id, output code_bit);
    modport ctl (output preload, output advance, output net_id, output tx_id, input code_bit);
endinterface : wpi_gen_if

// [verilog/wpi_kasami_gen.sv]
/*
 three-tier linear feedback sequence generator with parallel preload.
 assumes preload and advance are never asserted together.
*/
`timescale 1ns/100ps
module wpi_kasami_gen #(
    parameter logic [wpi_pkg::TIER_W-1:0] TAPS1 = wpi_pkg::TAPS_TIER1,
    parameter logic [wpi_pkg::TIER_W-1:0] TAPS2 = wpi_pkg::TAPS_TIER2,
    parameter logic [wpi_pkg::TIER_W-1:0] TAPS3 = wpi_pkg::TAPS_TIER3
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    wpi_gen_if.gen    g
);
    localparam int TW = wpi_pkg::TIER_W;
    localparam int PADW = TW - wpi_pkg::ID_W;

    logic [TW-1:0] tier_r [3];
    logic [TW-1:0] seed   [3];
    logic [TW-1:0] taps   [3];
    logic [2:0]    tier_out;

    // ------------------------------------------------------------
    // seeds: tier 1 fixed, tiers 2 and 3 from the identifiers
    // ------------------------------------------------------------
    assign seed[0] = TW'(1) << wpi_pkg::TIER1_X;
    assign seed[1] = {{PADW{1'b0}}, g.net_id};
    assign seed[2] = {{PADW{1'b0}}, g.tx_id};
    assign taps[0] = TAPS1;
    assign taps[1] = TAPS2;
    assign taps[2] = TAPS3;

    // ------------------------------------------------------------
    // tiers
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++)
    begin : g_tier
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                tier_r[i] <= '0;
            else if (g.preload)
                tier_r[i] <= seed[i];
            else if (g.advance)
                tier_r[i] <= {^(tier_r[i] & taps[i]), tier_r[i][TW-1:1]};
        end
        assign tier_out[i] = tier_r[i][0];
    end

    assign g.code_bit = ^tier_out;
endmodule : wpi_kasami_gen

// [verilog/wpi_amp_sel.sv]
/*
 registered bury-ratio to amplitude lookup.
 assumes the code changes only between fields.
*/
`timescale 1ns/100ps
module wpi_amp_sel (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic [wpi_pkg::BURY_W-1:0]   bury_code,
    output logic      [wpi_pkg::AMP_W-1:0]    amp
);
    logic [wpi_pkg::AMP_W-1:0] amp_nxt;

    // ------------------------------------------------------------
    // table: 3 db steps from -21 db, last code off
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (bury_code)
            3'h0:    amp_nxt = wpi_pkg::AMP_M21;
            3'h1:    amp_nxt = wpi_pkg::AMP_M24;
            3'h2:    amp_nxt = wpi_pkg::AMP_M27;
            3'h3:    amp_nxt = wpi_pkg::AMP_M30;
            3'h4:    amp_nxt = wpi_pkg::AMP_M33;
            3'h5:    amp_nxt = wpi_pkg::AMP_M36;
            3'h6:    amp_nxt = wpi_pkg::AMP_M39;
            3'h7:    amp_nxt = wpi_pkg::AMP_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            amp <= wpi_pkg::AMP_M30;
        else
            amp <= amp_nxt;
    end
endmodule : wpi_amp_sel

// [verif/wpi_sym_src.sv]
/*
 stand-in for the exciter symbol path feeding the injector.
 assumes callers sit on a falling edge of sys_clk.
*/
`timescale 1ns/100ps
module wpi_sym_src (
    input  wire logic                           sys_clk,
    output logic                                sym_valid,
    output logic                                field_sync,
    output logic signed [wpi_pkg::SYM_W-1:0]    host_sym
);
    initial
    begin
        sym_valid  = 1'b0;
        field_sync = 1'b0;
        host_sym   = '0;
    end
    task automatic send(input logic fs, input logic [wpi_pkg::SYM_W-1:0] h);
        sym_valid  = 1'b1;
        field_sync = fs;
        host_sym   = h;
        @(negedge sys_clk);
    endtask : send
    // stale data flipped so a late sample never looks right
    task automatic idle();
        sym_valid = 1'b0;
        host_sym  = ~host_sym;
        @(negedge sys_clk);
    endtask : idle
endmodule : wpi_sym_src

// [verif/wpi_injector_test.sv]
/*
 self-checking bench of the injector: packets, framing, levels, inversion.
 assumes a shortened field; a full one would cost 260k cycles.
*/
`timescale 1ns/100ps
module wpi_injector_test;
    localparam int NF = 300;
    localparam logic [9:0] AMP [8] = '{wpi_pkg::AMP_M21, wpi_pkg::AMP_M24,
        wpi_pkg::AMP_M27, wpi_pkg::AMP_M30, wpi_pkg::AMP_M33, wpi_pkg::AMP_M36,
        wpi_pkg::AMP_M39, wpi_pkg::AMP_ZERO};
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ret_invert = 1'b0;
    logic [7:0]  own_purpose = 8'h00;
    logic        pkt_valid = 1'b0;
    logic        pkt_start = 1'b0;
    logic [7:0]  pkt_byte = 8'h00;
    logic        sym_valid, field_sync, out_valid, wm_active, inverting, cfg_taken;
    logic [11:0] host_sym, net_r, tx_r;
    logic [12:0] out_sym;
    logic [2:0]  bury_now;
    logic [15:0] t1, t2, t3;
    int          err_total = 0;
    int          checks = 0;
    always #4 sys_clk = ~sys_clk;
    wpi_sym_src src (.sys_clk(sys_clk), .sym_valid(sym_valid), .field_sync(field_sync),
        .host_sym(host_sym));
    wpi_injector #(.FIELD_SYMS(18'd300)) dut (.sys_clk(sys_clk), .rst(rst),
        .sym_valid(sym_valid), .field_sync(field_sync), .host_sym(host_sym),
        .ret_invert(ret_invert), .own_purpose(own_purpose), .pkt_valid(pkt_valid),
        .pkt_start(pkt_start), .pkt_byte(pkt_byte), .out_sym(out_sym),
        .out_valid(out_valid), .wm_active(wm_active), .inverting(inverting),
        .bury_now(bury_now), .cfg_taken(cfg_taken));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    function automatic logic [15:0] step(input logic [15:0] s, input logic [15:0] tp);
        return {^(s & tp), s[15:1]};
    endfunction : step
    task automatic send_pkt(input logic [12:0] pid, input logic [7:0] pp,
        input logic [2:0] code, input logic [11:0] n, input logic [11:0] t, input logic ok);
        logic [7:0] b;
        for (int i = 0; i < 188; i++)
        begin
            case (i)
                0: b = wpi_pkg::TS_SYNC;
                1: b = {3'h0, pid[12:8]};
                2: b = pid[7:0];
                4: b = pp;
                5: b = {4'h0, n[11:8]};
                6: b = n[7:0];
                7: b = {4'h0, t[11:8]};
                8: b = t[7:0];
                9: b = {5'h0, code};
                default: b = 8'(i);
            endcase
            pkt_valid = 1'b1;
            pkt_start = (i == 0);
            pkt_byte  = b;
            @(negedge sys_clk);
            if (i == 90)
            begin
                pkt_valid = 1'b0; // a gap only pauses parsing
                @(negedge sys_clk);
            end
        end
        chk({12'h0, cfg_taken}, {12'h0, ok});
        pkt_valid = 1'b0;
        if (ok)
        begin
            net_r = n;
            tx_r  = t;
        end
        @(negedge sys_clk);
    endtask : send_pkt
    task automatic run_field(input logic inv, input logic [2:0] code);
        logic [11:0] h;
        logic [12:0] e;
        logic        c;
        ret_invert = inv;
        for (int i = 0; i < 4; i++)
        begin
            h = 12'(i * 291 + 5);
            src.send(1'b1, h);
            chk({12'h0, out_valid & ~wm_active}, 13'h1);
            chk(out_sym, {h[11], h});
            src.idle();
        end
        t1 = 16'h1 << wpi_pkg::TIER1_X;
        t2 = {4'h0, net_r};
        t3 = {4'h0, tx_r};
        chk({10'h0, bury_now}, {10'h0, code});
        chk({12'h0, inverting}, {12'h0, inv});
        for (int i = 0; i < NF + 3; i++)
        begin
            h = 12'(i * 1237);
            src.send(1'b0, h);
            c = t1[0] ^ t2[0] ^ t3[0] ^ inv;
            e = (i < NF) ? {h[11], h} + (c ? {3'h0, AMP[code]} : -{3'h0, AMP[code]}) : {h[11], h};
            chk({12'h0, wm_active}, {12'h0, i < NF});
            chk(out_sym, e);
            t1 = step(t1, wpi_pkg::TAPS_TIER1);
            t2 = step(t2, wpi_pkg::TAPS_TIER2);
            t3 = step(t3, wpi_pkg::TAPS_TIER3);
        end
        src.idle();
    endtask : run_field
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        chk({10'h0, bury_now}, {10'h0, wpi_pkg::BURY_NOMINAL});
        src.send(1'b0, 12'h155);
        chk({12'h0, wm_active}, 13'h0);
        src.idle();
        send_pkt(13'h1ffa, 8'h00, 3'h3, 12'ha5c, 12'h3c7, 1'b1);
        send_pkt(13'h1ffb, 8'h00, 3'h0, 12'h111, 12'h222, 1'b0);
        send_pkt(13'h1ffa, 8'h01, 3'h0, 12'h111, 12'h222, 1'b0);
        own_purpose = 8'h32;
        send_pkt(13'h1ffa, 8'h32, 3'h0, 12'h111, 12'h222, 1'b0);
        run_field(1'b0, 3'h3);
        for (int k = 0; k < 8; k++)
        begin
            own_purpose = 8'(k * 7);
            send_pkt(13'h1ffa, 8'(k * 7), 3'(k), 12'(k * 419 + 1),
                12'(4095 - k * 3), 1'b1);
            run_field(1'b0, 3'(k));
        end
        // a non-zero level, so that inverted bits show in the sum
        send_pkt(13'h1ffa, 8'h31, 3'h5, 12'h0f0, 12'h00f, 1'b1);
        run_field(1'b1, 3'h5);
        run_field(1'b0, 3'h5);
        report_and_stop();
    end
endmodule : wpi_injector_test
